// >>> hdl/fault_params.svh
`ifndef FAULT_PARAMS_SVH
`define FAULT_PARAMS_SVH
// sub-addresses of the fault registers
`define RST_MASK_ADDR    8'h0a
`define IRQ_MASK_ADDR    8'h0b
`define LIVE_STAT_ADDR   8'h0c
`define CAPT_STAT_ADDR   8'h0d
// warning config has no printed sub-address; chosen here
`define WARN_CFG_ADDR    8'h0e
// reset values
`define RST_MASK_RESET   8'hff
`define IRQ_MASK_RESET   8'h00
`define WARN_CFG_RESET   8'h00
// field positions
`define BOOST_PG_BIT     6
`define OVERTEMP_BIT     6
`define LOW_INPUT_BIT    7
`define GLOBAL_RESET_BIT 7
// warning config fields; bits 3 and 2 are not stored
`define WARN_CFG_MASK    8'hf3
`define LOW_INPUT_MSB    6
`define LOW_INPUT_LSB    4
`define OVERTEMP_MSB     1
`define OVERTEMP_LSB     0
// pushbutton timing in units of the timing element
`define PRESS_LOW_UNITS   5000
`define PRESS_PULSE_UNITS 5000
`define PRESS_WAKE_UNITS  40000
`define WAKE_ON_UNITS     500
`define HARD_RESET_UNITS  500
`define HARD_RESET_DUR    100
`endif

// >>> hdl/fault_pkg.sv
package fault_pkg;
  // host register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // analog warning and fault inputs
  typedef struct packed {
    logic       boost_mode;
    logic       die_overtemp_warning;
    logic       low_input_warning;
    logic [6:0] regulator_power_good;
  } fault_in_t;

  // state of the fault core
  typedef struct packed {
    logic [7:0] rst_mask;
    logic [7:0] irq_mask;
    logic [7:0] warn_cfg;
    logic [7:0] captured;
    logic [7:0] rdata;
    logic       irq_active;
  } fault_state_t;
endpackage

// >>> hdl/fault_gate.sv
`timescale 1ns/100ps
// one mask-gated fault output, low when any enabled source is bad
module fault_gate
  import fault_pkg::*;
(
  // fault sources and mask
  input  wire logic [6:0] bad,
  input  wire logic [6:0] mask,
  // gated active-low output
  output logic            out_n
);
  logic [6:0] hit;

  // one gate per power-good source
  genvar i;
  generate
    for (i = 0; i < 7; i++)
    begin : g_src
      assign hit[i] = bad[i] & mask[i];
    end
  endgenerate

  assign out_n = ~|hit;
endmodule // fault_gate

// >>> hdl/pmic_fault_status_mask.sv
// Contract
// - reset mask resets to ff; each set bit lets its fault pull reset low.
// - interrupt mask shares that layout at its own address, resets to 00.
// - mask bit 6 counts only while the led driver is a boost regulator.
// - a low reset or interrupt output signals a fault; status tells why.
// - live status shows power-good 1 to 6 in bits 0 to 5, bits 6 and 7 zero.
// - captured status: power-good 1-6, over-temperature 6, low-input 7.
// - on the interrupt event the fault condition is stored and held.
// - the clear command clears every captured status bit; a capture in the same cycle wins.
// - a power-good bit is zero when its output is over 8 percent low.
// - both status registers ignore host writes.
// - warning config resets to zero: reset request, low-input, overtemp.
// - pushbutton intervals are fixed multiples of one timing element.
`timescale 1ns/100ps
`include "fault_params.svh"
module pmic_fault_status_mask
  import fault_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // host register port
  input  wire reg_req_t   req,
  input  wire logic       clear_latched_faults_cmd,
  output logic [7:0]      rdata,
  // fault inputs
  input  wire fault_in_t  faults,
  // fault outputs
  output logic            fault_reset_out_n,
  output logic            fault_irq_out_n,
  // configuration outputs to analog side
  output logic            global_reset_req,
  output logic [2:0]      low_input_threshold,
  output logic [1:0]      overtemp_threshold,
  // pushbutton timing scale, in timing elements
  output logic [15:0]     press_low_interval,
  output logic [15:0]     press_status_pulse_width,
  output logic [15:0]     press_wake_interval,
  output logic [15:0]     press_hard_reset_interval,
  output logic [15:0]     hard_reset_duration
);
  // ***************************************************
  // fault gating
  // ***************************************************
  fault_state_t st_reg;
  fault_state_t st_next;
  logic [6:0]   pg_bad;
  logic [6:0]   rst_en;
  logic [6:0]   irq_en;
  logic [7:0]   live;
  logic [7:0]   snapshot;
  logic         irq_n;

  // power-good low means output over 8 percent low; fault is its inverse
  assign pg_bad = ~faults.regulator_power_good;
  // boost source is ignored unless the led driver is a boost regulator
  assign rst_en = {st_reg.rst_mask[6] & faults.boost_mode,
                   st_reg.rst_mask[5:0]};
  assign irq_en = {st_reg.irq_mask[6] & faults.boost_mode,
                   st_reg.irq_mask[5:0]};

  fault_gate u_rst_gate (
    .bad   (pg_bad),
    .mask  (rst_en),
    .out_n (fault_reset_out_n)
  );

  fault_gate u_irq_gate (
    .bad   (pg_bad),
    .mask  (irq_en),
    .out_n (irq_n)
  );

  assign fault_irq_out_n = irq_n;

  // ***************************************************
  // status views
  // ***************************************************
  // live view carries only regulators one to six
  assign live = {2'b00, faults.regulator_power_good[5:0]};
  assign snapshot = {faults.low_input_warning,
                     faults.die_overtemp_warning,
                     faults.regulator_power_good[5:0]};

  // ***************************************************
  // register state
  // ***************************************************
  // next state: host writes, capture on interrupt edge, clear command
  always_comb
  begin
    st_next = st_reg;
    st_next.irq_active = ~irq_n;
    if (req.wr)
    begin
      case (req.addr)
        `RST_MASK_ADDR: st_next.rst_mask = req.wdata;
        `IRQ_MASK_ADDR: st_next.irq_mask = req.wdata;
        `WARN_CFG_ADDR: st_next.warn_cfg = req.wdata & `WARN_CFG_MASK;
        default:        st_next.rst_mask = st_reg.rst_mask;
      endcase
    end
    // clear first so a simultaneous capture wins
    if (clear_latched_faults_cmd)
      st_next.captured = 8'h00;
    if (~irq_n && !st_reg.irq_active)
      st_next.captured = snapshot;
    if (req.rd)
    begin
      case (req.addr)
        `RST_MASK_ADDR:  st_next.rdata = st_reg.rst_mask;
        `IRQ_MASK_ADDR:  st_next.rdata = st_reg.irq_mask;
        `LIVE_STAT_ADDR: st_next.rdata = live;
        `CAPT_STAT_ADDR: st_next.rdata = st_reg.captured;
        `WARN_CFG_ADDR:  st_next.rdata = st_reg.warn_cfg;
        default:         st_next.rdata = 8'h00;
      endcase
    end
  end

  // register the whole state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg.rst_mask   <= `RST_MASK_RESET;
      st_reg.irq_mask   <= `IRQ_MASK_RESET;
      st_reg.warn_cfg   <= `WARN_CFG_RESET;
      st_reg.captured   <= 8'h00;
      st_reg.rdata      <= 8'h00;
      st_reg.irq_active <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign rdata               = st_reg.rdata;
  assign global_reset_req    = st_reg.warn_cfg[`GLOBAL_RESET_BIT];
  assign low_input_threshold = st_reg.warn_cfg[`LOW_INPUT_MSB:`LOW_INPUT_LSB];
  assign overtemp_threshold  = st_reg.warn_cfg[`OVERTEMP_MSB:`OVERTEMP_LSB];
  // fixed multiples of the timing element
  assign press_low_interval        = 16'(`PRESS_LOW_UNITS);
  assign press_status_pulse_width  = 16'(`PRESS_PULSE_UNITS);
  assign press_wake_interval       = 16'(`PRESS_WAKE_UNITS);
  assign press_hard_reset_interval = 16'(`HARD_RESET_UNITS);
  assign hard_reset_duration       = 16'(`HARD_RESET_DUR);

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rst_mask_gate_a: assert property (
    (faults.regulator_power_good[0] == 1'b0 && st_reg.rst_mask[0])
      |-> !fault_reset_out_n)
    else $error("reset output not driven low by masked fault");
  irq_mask_gate_a: assert property (
    (faults.regulator_power_good[1] == 1'b0 && st_reg.irq_mask[1])
      |-> !fault_irq_out_n)
    else $error("interrupt output not driven low by masked fault");
  irq_idle_high_a: assert property (
    (st_reg.irq_mask == 8'h00) |-> fault_irq_out_n)
    else $error("interrupt output low with empty mask");
  boost_bit_ignored_a: assert property (
    (!faults.boost_mode && &faults.regulator_power_good[5:0])
      |-> fault_reset_out_n && fault_irq_out_n)
    else $error("boost source acted outside boost mode");
  capture_on_edge_a: assert property (
    (!irq_n && !st_reg.irq_active) |=> st_reg.captured == $past(snapshot))
    else $error("fault snapshot not captured");
  clear_captured_a: assert property (
    (clear_latched_faults_cmd && !(!irq_n && !st_reg.irq_active))
      |=> st_reg.captured == 8'h00)
    else $error("captured status not cleared");
  live_read_a: assert property (
    (req.rd && req.addr == `LIVE_STAT_ADDR) |=> rdata[7:6] == 2'b00)
    else $error("live status unused bits not zero");
  status_write_a: assert property (
    (req.wr && req.addr == `CAPT_STAT_ADDR && !clear_latched_faults_cmd
      && !(!irq_n && !st_reg.irq_active))
      |=> st_reg.captured == $past(st_reg.captured))
    else $error("write changed captured status");
  warn_unused_a: assert property (
    st_reg.warn_cfg[3:2] == 2'b00)
    else $error("warning config unused bits set");

  // register port: writes and reads take effect one edge after the strobe
  rst_mask_write_a: assert property (
    (req.wr && req.addr == `RST_MASK_ADDR)
      |=> st_reg.rst_mask == $past(req.wdata))
    else $error("reset mask write did not land");
  irq_mask_write_a: assert property (
    (req.wr && req.addr == `IRQ_MASK_ADDR)
      |=> st_reg.irq_mask == $past(req.wdata))
    else $error("interrupt mask write did not land");
  warn_write_a: assert property (
    (req.wr && req.addr == `WARN_CFG_ADDR)
      |=> st_reg.warn_cfg == ($past(req.wdata) & `WARN_CFG_MASK))
    else $error("warning config write did not land");
  live_value_a: assert property (
    (req.rd && req.addr == `LIVE_STAT_ADDR)
      |=> rdata == {2'b00, $past(faults.regulator_power_good[5:0])})
    else $error("live status read does not match power-good");
  capt_read_a: assert property (
    (req.rd && req.addr == `CAPT_STAT_ADDR)
      |=> rdata == $past(st_reg.captured))
    else $error("captured status read does not match");
  rdata_hold_a: assert property (
    !req.rd |=> $stable(rdata))
    else $error("read data changed without a read");
  // fault outputs against the live power-good inputs
  rst_boost_gate_a: assert property (
    (faults.boost_mode && !faults.regulator_power_good[6]
      && st_reg.rst_mask[6]) |-> !fault_reset_out_n)
    else $error("boost source ignored in boost mode");
  pg_good_quiet_a: assert property (
    (&faults.regulator_power_good) |-> fault_reset_out_n && fault_irq_out_n)
    else $error("fault output low with all regulators good");

  capture_c: cover property (!irq_n && !st_reg.irq_active);
  clear_c:   cover property (clear_latched_faults_cmd && |st_reg.captured);
  reset_c:   cover property (!fault_reset_out_n);
  boost_c:   cover property (faults.boost_mode && !fault_irq_out_n);
  read_c:    cover property (req.rd && req.addr == `CAPT_STAT_ADDR);
endmodule // pmic_fault_status_mask

// >>> verification/host_model.sv
`timescale 1ns/100ps
// ****************************************
// host side of the register port
// ****************************************
module host_model
  import fault_pkg::*;
(
  // clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  // requests to the device
  output reg_req_t        req,
  output logic            clear_latched_faults_cmd
);
  // idle bus from time zero
  initial
  begin
    req = '0;
    clear_latched_faults_cmd = 1'b0;
  end

  // one write strobe, held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  // read data is registered, so it is settled by the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    d = rdata;
  endtask

  // one-cycle clear pulse for the captured status
  task automatic clear_faults();
    @(negedge clk);
    clear_latched_faults_cmd = 1'b1;
    @(negedge clk);
    clear_latched_faults_cmd = 1'b0;
  endtask
endmodule // host_model

// >>> verification/tb_pmic_fault_status_mask.sv
`timescale 1ns/100ps
`include "fault_params.svh"
module tb_pmic_fault_status_mask;
  import fault_pkg::*;
  // one table row: masks and faults beside the expected pins
  typedef struct packed {
    logic [7:0] rmask;
    logic [7:0] imask;
    logic [6:0] pg;
    logic       boost;
    logic       rst_n;
    logic       irq_n;
  } row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  fault_in_t   faults = '0;
  reg_req_t    req;
  logic        clr;
  logic [7:0]  rdata, d;
  logic        rst_n, irq_n, grr;
  logic [2:0]  lit;
  logic [1:0]  ott;
  logic [15:0] t0, t1, t2, t3, t4;
  int          failures = 0;
  int          samples_checked = 0;
  // bit 6 rows show the boost source counting only in boost mode
  row_t rows [8] = '{
    '{8'hff, 8'h00, 7'h7f, 1'b0, 1'b1, 1'b1},
    '{8'hff, 8'h00, 7'h7e, 1'b0, 1'b0, 1'b1},
    '{8'h00, 8'h01, 7'h7e, 1'b0, 1'b1, 1'b0},
    '{8'h00, 8'h40, 7'h3f, 1'b0, 1'b1, 1'b1},
    '{8'h00, 8'h40, 7'h3f, 1'b1, 1'b1, 1'b0},
    '{8'h40, 8'h00, 7'h3f, 1'b1, 1'b0, 1'b1},
    '{8'hbf, 8'h02, 7'h40, 1'b0, 1'b0, 1'b0},
    '{8'h3f, 8'h00, 7'h7f, 1'b0, 1'b1, 1'b1}};

  // 10 MHz clock
  always #50 clk = ~clk;

  host_model host (.clk(clk), .rdata(rdata), .req(req),
    .clear_latched_faults_cmd(clr));

  pmic_fault_status_mask uut (.clk(clk), .rst(rst), .req(req),
    .clear_latched_faults_cmd(clr), .rdata(rdata), .faults(faults),
    .fault_reset_out_n(rst_n), .fault_irq_out_n(irq_n),
    .global_reset_req(grr), .low_input_threshold(lit),
    .overtemp_threshold(ott), .press_low_interval(t0),
    .press_status_pulse_width(t1), .press_wake_interval(t2),
    .press_hard_reset_interval(t3), .hard_reset_duration(t4));

  // ****************************************
  // compare and closing
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bytes and pins go through the word compare, widened on purpose
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk({8'h00, got}, {8'h00, exp});
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic final_report();
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // the whole run is well under a thousand cycles
  initial
  begin
    #1000000;
    failures++;
    final_report();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    host.rd(8'h0b, d);
    chk8(d, 8'h00);
    host.rd(8'h0d, d);
    chk8(d, 8'h00);
    // each timing word on its own, so no word hides behind another
    chk(t0, 16'h1388);
    chk(t1, 16'h1388);
    chk(t2, 16'h9c40);
    chk(t3, 16'h01f4);
    chk(t4, 16'h0064);
    foreach (rows[i])
    begin
      host.wr(8'h0a, rows[i].rmask);
      host.wr(8'h0b, rows[i].imask);
      faults.boost_mode = rows[i].boost;
      faults.regulator_power_good = rows[i].pg;
      host.rd(8'h0c, d);
      chk8(d, {2'b00, rows[i].pg[5:0]});
      chk1(rst_n, rows[i].rst_n);
      chk1(irq_n, rows[i].irq_n);
    end
    // status is read-only and unmapped places read zero
    host.wr(8'h0c, 8'h00);
    host.wr(8'h20, 8'hff);
    host.rd(8'h0c, d);
    chk8(d, 8'h3f);
    host.rd(8'h20, d);
    chk8(d, 8'h00);
    // capture on the interrupt, then hold, then clear
    host.wr(8'h0b, 8'h3f);
    host.clear_faults();
    faults.die_overtemp_warning = 1'b1;
    faults.regulator_power_good = 7'h7b;
    #1;
    chk1(irq_n, 1'b0);
    @(negedge clk);
    faults.die_overtemp_warning = 1'b0;
    faults.regulator_power_good = 7'h7f;
    host.wr(8'h0d, 8'hff);
    host.rd(8'h0d, d);
    chk8(d, 8'h7b);
    host.clear_faults();
    host.rd(8'h0d, d);
    chk8(d, 8'h00);
    // low-input warning lands in bit 7 of a fresh capture
    faults.low_input_warning = 1'b1;
    faults.regulator_power_good = 7'h7e;
    @(negedge clk);
    faults.low_input_warning = 1'b0;
    faults.regulator_power_good = 7'h7f;
    host.rd(8'h0d, d);
    chk8(d, 8'hbe);
    // warning config fields, unused bits read zero
    host.wr(`WARN_CFG_ADDR, 8'hff);
    host.rd(`WARN_CFG_ADDR, d);
    chk8(d, 8'hf3);
    chk8({2'b00, grr, lit, ott}, 8'h3f);
    // second reset in mid-run restores defaults
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    host.rd(8'h0a, d);
    chk8(d, 8'hff);
    host.rd(`WARN_CFG_ADDR, d);
    chk8(d, 8'h00);
    final_report();
  end
endmodule // tb_pmic_fault_status_mask
